// ### rtl/mlpwm_core.sv
// Purpose: control core of an 18-channel led pwm driver
// Assumes: byte register port from a serial slave; fault comparators outside
// Notes: registers kept through any shutdown; pin is asynchronous
`include "mlpwm_defines.svh"
module mlpwm_core (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // shutdown pin, asynchronous
    input wire logic shutdown_pin_n,
    // register port from the serial slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic serial_reset,
    // analog fault comparators per output
    input wire logic [`MLPWM_NUM_CH-1:0] open_sense,
    input wire logic [`MLPWM_NUM_CH-1:0] short_sense,
    // outputs to the current sinks
    output logic [`MLPWM_NUM_CH-1:0] led_output,
    output logic [`MLPWM_NUM_CH*8-1:0] channel_scale_value,
    output logic [7:0] global_current_level,
    output logic analog_enable
);
    import mlpwm_pkg::*;

    localparam int NCH = `MLPWM_NUM_CH;

    logic [7:0] ctrl_reg;
    logic [7:0] duty_bytes [0:2*NCH-1];
    mlpwm_pkg::mlpwm_duty_t active_duty [0:NCH-1];
    logic [7:0] scale_reg [0:NCH-1];
    logic [7:0] gcc_reg;
    logic [1:0] detect_select;
    logic [NCH-1:0] fault_reg;
    logic [7:0] spread_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic [7:0] rdata_reg;
    logic [NCH-1:0] out_reg;
    logic serial_reset_reg;
    logic [NCH-1:0] open_meta_reg, open_sync_reg, short_meta_reg, short_sync_reg;
    logic soft_on;
    logic pin_rise;
    logic upd_write;

    mlpwm_timer_if tif ();

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // address range test used by both write and read decode
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // duty bytes: odd offset low, even offset high; mask to chosen resolution
    function automatic mlpwm_duty_t duty_of(input logic [7:0] hi, input logic [7:0] lo, input mlpwm_res_e r);
        logic [15:0] v;
        v = {hi, lo};
        case (r)
            MLPWM_RES_8: duty_of = {8'h00, v[7:0]};
            MLPWM_RES_10: duty_of = {6'h00, v[9:0]};
            MLPWM_RES_12: duty_of = {4'h0, v[11:0]};
            default: duty_of = v;
        endcase
    endfunction : duty_of

    // ---------------------------------------------------------------
    // shutdown pin
    // ---------------------------------------------------------------
    // two-stage sync, then edge detect on the settled copy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= shutdown_pin_n;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign pin_rise = pin_sync_reg && !pin_prev_reg;

    // serial slave reset pulse on release; register file untouched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_reset_reg <= 1'b0;
        end else begin
            serial_reset_reg <= pin_rise;
        end
    end

    assign serial_reset = serial_reset_reg;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // writes accepted regardless of either shutdown
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `MLPWM_CTRL_RESET;
            gcc_reg <= 8'h00;
            spread_reg <= `MLPWM_SPREAD_RESET;
            detect_select <= 2'b00;
        end else if (reg_wr) begin
            case (reg_addr)
                `MLPWM_ADDR_CTRL: ctrl_reg <= reg_wdata;
                `MLPWM_ADDR_GLOBAL_CUR: gcc_reg <= reg_wdata;
                `MLPWM_ADDR_SPREAD: spread_reg <= reg_wdata;
                `MLPWM_ADDR_DETECT: detect_select <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // duty staging bytes; no effect until update key
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 2*NCH; i++) begin
                duty_bytes[i] <= 8'h00;
            end
        end else if (reg_wr && in_range(reg_addr, `MLPWM_ADDR_DUTY_FIRST, `MLPWM_ADDR_DUTY_LAST)) begin
            duty_bytes[6'(reg_addr - `MLPWM_ADDR_DUTY_FIRST)] <= reg_wdata;
        end
    end

    // scale values drive the sinks directly, no update needed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                scale_reg[i] <= 8'h00;
            end
        end else if (reg_wr && in_range(reg_addr, `MLPWM_ADDR_SCALE_FIRST, `MLPWM_ADDR_SCALE_LAST)) begin
            scale_reg[5'(reg_addr - `MLPWM_ADDR_SCALE_FIRST)] <= reg_wdata;
        end
    end

    assign soft_on = ctrl_reg[`MLPWM_CTRL_SSD_BIT];
    assign upd_write = reg_wr && (reg_addr == `MLPWM_ADDR_UPDATE) && (reg_wdata == `MLPWM_UPDATE_KEY)
        && pin_sync_reg && soft_on;

    // ---------------------------------------------------------------
    // active duty
    // ---------------------------------------------------------------
    // staged bytes move to active set only on the keyed update write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                active_duty[i] <= 16'h0000;
            end
        end else if (upd_write) begin
            for (int i = 0; i < NCH; i++) begin
                active_duty[i] <= {duty_bytes[2*i+1], duty_bytes[2*i]};
            end
        end
    end

    // ---------------------------------------------------------------
    // timer link
    // ---------------------------------------------------------------
    assign tif.res = mlpwm_res_e'(ctrl_reg[`MLPWM_CTRL_RES_LSB +: 2]);
    assign tif.osc = ctrl_reg[`MLPWM_CTRL_OSC_LSB +: 3];
    assign tif.spread_range = spread_reg[`MLPWM_SPREAD_RNG_LSB +: 2];
    assign tif.ss_en = spread_reg[`MLPWM_SPREAD_SSP_BIT];

    mlpwm_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .tif(tif.timer)
    );

    // ---------------------------------------------------------------
    // channel outputs
    // ---------------------------------------------------------------
    // pwm is the only mode; either shutdown forces every sink off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_reg <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                out_reg[i] <= soft_on && pin_sync_reg
                    && (tif.count < duty_of(active_duty[i][15:8], active_duty[i][7:0], tif.res));
            end
        end
    end

    assign led_output = out_reg;
    assign analog_enable = pin_sync_reg;
    assign global_current_level = gcc_reg;

    // per-channel scale bytes flattened for the sinks
    always_comb begin
        channel_scale_value = '0;
        for (int i = 0; i < NCH; i++) begin
            channel_scale_value[i*8 +: 8] = scale_reg[i];
        end
    end

    // ---------------------------------------------------------------
    // fault capture
    // ---------------------------------------------------------------
    // comparators are analog, so synchronise before sampling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_meta_reg <= '0;
            open_sync_reg <= '0;
            short_meta_reg <= '0;
            short_sync_reg <= '0;
        end else begin
            open_meta_reg <= open_sense;
            open_sync_reg <= open_meta_reg;
            short_meta_reg <= short_sense;
            short_sync_reg <= short_meta_reg;
        end
    end

    // only one kind is kept; disabled codes freeze the last result
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_reg <= '0;
        end else begin
            case (detect_select)
                2'b10: fault_reg <= short_sync_reg;
                2'b11: fault_reg <= open_sync_reg;
                default: fault_reg <= fault_reg;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    // read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            if (in_range(reg_addr, `MLPWM_ADDR_DUTY_FIRST, `MLPWM_ADDR_DUTY_LAST)) begin
                rdata_reg <= duty_bytes[6'(reg_addr - `MLPWM_ADDR_DUTY_FIRST)];
            end else if (in_range(reg_addr, `MLPWM_ADDR_SCALE_FIRST, `MLPWM_ADDR_SCALE_LAST)) begin
                rdata_reg <= scale_reg[5'(reg_addr - `MLPWM_ADDR_SCALE_FIRST)];
            end else begin
                case (reg_addr)
                    `MLPWM_ADDR_CTRL: rdata_reg <= ctrl_reg;
                    `MLPWM_ADDR_GLOBAL_CUR: rdata_reg <= gcc_reg;
                    `MLPWM_ADDR_SPREAD: rdata_reg <= spread_reg;
                    `MLPWM_ADDR_DETECT: rdata_reg <= {6'h00, detect_select};
                    `MLPWM_ADDR_STATUS0: rdata_reg <= fault_reg[7:0];
                    `MLPWM_ADDR_STATUS1: rdata_reg <= fault_reg[15:8];
                    `MLPWM_ADDR_STATUS2: rdata_reg <= {6'h00, fault_reg[17:16]};
                    default: rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_reg;
endmodule : mlpwm_core

// ### rtl/mlpwm_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the led pwm core
// Assumes: byte-wide register port, 50 MHz core clock
// Notes: included by both design modules and the test modules
//
// Notes on behaviour
// - each of 18 outputs has 256, 1024, 4096 or 65536 duty steps.
// - duty step is high and low duty bytes read as one binary value.
// - after reset, 8-bit resolution at about 62 kHz from a 16 MHz base; the 3-cycle tick of the 50 MHz clock gives about 65 kHz.
// - switching frequency set by oscillator select and resolution select fields.
// - all channels start their on-period at the same point of the period.
// - each output current scaled by its own 8-bit scale value.
// - detect select moving to 10 captures shorts, to 11 captures opens.
// - one fault status bit per output, open or short per selected type.
// - spread range field chooses plus or minus 5, 15, 24 or 34 percent; the timer only lengthens the divider, by up to 1, 2, 3 or 4 cycles.
// - pwm is the only working mode besides shutdown.
// - all register contents survive software and hardware shutdown.
// - soft shutdown bit at 0 turns off all current sources.
// - shutdown pin low holds hardware shutdown; high releases it.
// - rising edge of shutdown pin resets the serial interface, not registers.
// - register access keeps working during hardware shutdown.
// - writing 00h to update register, pin high and bit set, loads duty.
// - scale values take effect immediately when written.
// - detect select 00 and 01 mean detection disabled.
`ifndef MLPWM_DEFINES_SVH
`define MLPWM_DEFINES_SVH

`define MLPWM_NUM_CH 18
`define MLPWM_ADDR_CTRL 8'h00
`define MLPWM_ADDR_DUTY_FIRST 8'h01
`define MLPWM_ADDR_DUTY_LAST 8'h24
`define MLPWM_ADDR_UPDATE 8'h49
`define MLPWM_ADDR_SCALE_FIRST 8'h4a
`define MLPWM_ADDR_SCALE_LAST 8'h5b
`define MLPWM_ADDR_GLOBAL_CUR 8'h6e
`define MLPWM_ADDR_DETECT 8'h71
`define MLPWM_ADDR_STATUS0 8'h72
`define MLPWM_ADDR_STATUS1 8'h73
`define MLPWM_ADDR_STATUS2 8'h74
`define MLPWM_ADDR_SPREAD 8'h78
`define MLPWM_UPDATE_KEY 8'h00
// control fields: bit 0 soft shutdown, bits 2:1 resolution, bits 6:4 oscillator
`define MLPWM_CTRL_SSD_BIT 0
`define MLPWM_CTRL_RES_LSB 1
`define MLPWM_CTRL_OSC_LSB 4
`define MLPWM_CTRL_RESET 8'h00
`define MLPWM_SPREAD_RNG_LSB 2
`define MLPWM_SPREAD_SSP_BIT 4
`define MLPWM_SPREAD_RESET 8'h00
// base tick: 16 MHz approximated from the 50 MHz clock
`define MLPWM_CLK_HZ 50000000
`define MLPWM_OSC_HZ 16000000
`define MLPWM_TICK_CYCLES (`MLPWM_CLK_HZ / `MLPWM_OSC_HZ)
`define MLPWM_SPREAD_STEP_CYCLES 1024

`endif

// ### rtl/mlpwm_pkg.sv
// Purpose: shared types of the led pwm core
// Assumes: defines header alongside
// Notes: types only
package mlpwm_pkg;
    typedef enum logic [1:0] {MLPWM_RES_8, MLPWM_RES_10, MLPWM_RES_12, MLPWM_RES_16} mlpwm_res_e;
    typedef logic [15:0] mlpwm_duty_t;
endpackage : mlpwm_pkg

// ### rtl/mlpwm_timer_if.sv
// Purpose: carries the period timing between the core and its timer
// Assumes: one clock
// Notes: timer drives period start and counter
interface mlpwm_timer_if;
    import mlpwm_pkg::*;
    mlpwm_res_e res;
    logic [2:0] osc;
    logic [1:0] spread_range;
    logic ss_en;
    logic [15:0] count;
    logic period_start;
    modport timer (input res, input osc, input spread_range, input ss_en, output count, output period_start);
    modport core (output res, output osc, output spread_range, output ss_en, input count, input period_start);
endinterface : mlpwm_timer_if

// ### rtl/mlpwm_timer.sv
// Purpose: free-running pwm period counter with frequency select and spread
// Assumes: 50 MHz clock
// Notes: spread lengthens the tick divider above its nominal value
`include "mlpwm_defines.svh"
module mlpwm_timer (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // timing link to the core
    mlpwm_timer_if.timer tif
);
    import mlpwm_pkg::*;

    logic [9:0] tick_cnt_reg;
    logic [9:0] tick_lim; // ten bits: slowest select plus spread reaches 387
    logic [15:0] count_reg;
    logic [10:0] ss_cnt_reg;
    logic [3:0] ss_off_reg;
    logic ss_up_reg;
    logic [3:0] ss_max;
    logic [15:0] top;

    // ---------------------------------------------------------------
    // divider limits
    // ---------------------------------------------------------------
    // span chosen by range field; coarse because the base divider is only ~3 cycles
    always_comb begin
        case (tif.spread_range)
            2'd0: ss_max = 4'd1;
            2'd1: ss_max = 4'd2;
            2'd2: ss_max = 4'd3;
            default: ss_max = 4'd4;
        endcase
    end

    // oscillator select slows the base tick by powers of two
    always_comb begin
        tick_lim = 10'((`MLPWM_TICK_CYCLES << tif.osc) - 1);
        if (tif.ss_en) begin
            tick_lim = tick_lim + 10'(ss_off_reg);
        end
        case (tif.res)
            MLPWM_RES_8: top = 16'h00ff;
            MLPWM_RES_10: top = 16'h03ff;
            MLPWM_RES_12: top = 16'h0fff;
            default: top = 16'hffff;
        endcase
    end

    // ---------------------------------------------------------------
    // counters
    // ---------------------------------------------------------------
    // shared counter keeps every channel aligned
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_reg <= 10'h000;
            count_reg <= 16'h0000;
        end else if (tick_cnt_reg >= tick_lim) begin
            tick_cnt_reg <= 10'h000;
            count_reg <= (count_reg >= top) ? 16'h0000 : count_reg + 16'h0001;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 10'h001;
        end
    end

    // triangle sweep of the divider offset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ss_cnt_reg <= 11'h000;
            ss_off_reg <= 4'h0;
            ss_up_reg <= 1'b1;
        end else if (ss_cnt_reg == 11'(`MLPWM_SPREAD_STEP_CYCLES - 1)) begin
            ss_cnt_reg <= 11'h000;
            if (ss_up_reg && ss_off_reg >= ss_max) begin
                ss_up_reg <= 1'b0;
            end else if (!ss_up_reg && ss_off_reg == 4'h0) begin
                ss_up_reg <= 1'b1;
            end else begin
                ss_off_reg <= ss_up_reg ? ss_off_reg + 4'h1 : ss_off_reg - 4'h1;
            end
        end else begin
            ss_cnt_reg <= ss_cnt_reg + 11'h001;
        end
    end

    assign tif.count = count_reg;
    assign tif.period_start = (count_reg == 16'h0000) && (tick_cnt_reg == 10'h000);
endmodule : mlpwm_timer

// ### test/mlpwm_core_sva.sv
// Purpose: port-level checks of the led pwm core
// Assumes: one clock, asynchronous active-low reset
// Notes: shadows the soft shutdown bit from the write strobe only
`include "mlpwm_defines.svh"
module mlpwm_core_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pin and register port
    input wire logic shutdown_pin_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_reset,
    // fault inputs and sink outputs
    input wire logic [`MLPWM_NUM_CH-1:0] open_sense,
    input wire logic [`MLPWM_NUM_CH-1:0] short_sense,
    input wire logic [`MLPWM_NUM_CH-1:0] led_output,
    input wire logic [`MLPWM_NUM_CH*8-1:0] channel_scale_value,
    input wire logic [7:0] global_current_level,
    input wire logic analog_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic ssd_reg;

    // ----------------------------------------
    // shadow and assertions
    // ----------------------------------------
    // shadow of control bit 0, same timing as the register itself
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ssd_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `MLPWM_ADDR_CTRL) begin
            ssd_reg <= reg_wdata[`MLPWM_CTRL_SSD_BIT];
        end
    end
    property p_scale_write;
        reg_wr && reg_addr == `MLPWM_ADDR_SCALE_LAST |=> channel_scale_value[143:136] == $past(reg_wdata);
    endproperty
    a_scale_write: assert property (p_scale_write) else $error("last scale byte not applied");
    property p_level_write;
        reg_wr && reg_addr == `MLPWM_ADDR_GLOBAL_CUR |=> global_current_level == $past(reg_wdata);
    endproperty
    a_level_write: assert property (p_level_write) else $error("global level not applied");
    property p_level_read;
        reg_rd && reg_addr == `MLPWM_ADDR_GLOBAL_CUR |=> reg_rdata == global_current_level;
    endproperty
    a_level_read: assert property (p_level_read) else $error("global level read back wrong");
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
    property p_soft_off;
        !ssd_reg && !$past(ssd_reg) && !$past(ssd_reg, 2) |-> led_output == '0;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("output on in soft shutdown");
    property p_hard_off;
        !analog_enable && !$past(analog_enable) |-> led_output == '0;
    endproperty
    a_hard_off: assert property (p_hard_off) else $error("output on in hardware shutdown");
    property p_pin_low;
        !shutdown_pin_n [*3] |-> !analog_enable;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("analog enable high with pin low");
    property p_serial_pulse;
        serial_reset |=> !serial_reset;
    endproperty
    a_serial_pulse: assert property (p_serial_pulse) else $error("serial reset longer than a cycle");
    property p_serial_after_pin;
        $rose(shutdown_pin_n) |-> ##[1:6] serial_reset;
    endproperty
    a_serial_after_pin: assert property (p_serial_after_pin) else $error("no serial reset after pin rise");
    property p_regs_kept;
        serial_reset |-> $stable(channel_scale_value) && $stable(global_current_level);
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("registers changed at serial reset");
endmodule : mlpwm_core_sva

bind mlpwm_core mlpwm_core_sva u_sva (.clk(clk), .reset_n(reset_n), .shutdown_pin_n(shutdown_pin_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_reset(serial_reset), .open_sense(open_sense), .short_sense(short_sense), .led_output(led_output),
    .channel_scale_value(channel_scale_value), .global_current_level(global_current_level),
    .analog_enable(analog_enable));

// ### test/mlpwm_host_model.sv
// Purpose: host side of the byte register port
// Assumes: strobes are one-cycle pulses taken on the rising edge
// Notes: address goes to inverted junk after every access and data after every write, so nothing leans on stale values
`include "mlpwm_defines.svh"
module mlpwm_host_model (
    // clock
    input wire logic clk,
    // register port towards the core
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle port at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one write pulse, launched and dropped on falling edges
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : write_reg
    // read data is registered, so it is settled one falling edge later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : read_reg
    // duty load key; the caller decides whether pin and soft bit allow it
    task automatic update_duty();
        write_reg(`MLPWM_ADDR_UPDATE, `MLPWM_UPDATE_KEY);
    endtask : update_duty
endmodule : mlpwm_host_model

// ### test/test_multichannel_led_pwm_core.sv
// Purpose: self-checking bench of the led pwm core
// Assumes: base tick of MLPWM_TICK_CYCLES clocks, spread off while duty is measured
// Notes: duty is measured as on-cycles over whole periods, so phase does not matter
`include "mlpwm_defines.svh"
module test_multichannel_led_pwm_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, shutdown_pin_n, reg_wr, reg_rd, serial_reset, analog_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, global_current_level, rd;
    logic [`MLPWM_NUM_CH-1:0] open_sense, short_sense, led_output;
    logic [`MLPWM_NUM_CH*8-1:0] channel_scale_value;
    int err_count = 0;
    int checks_done = 0;
    int c1, c2, c3, bad, per, n, d, t;
    int res_t[4] = '{0, 0, 1, 2};
    int osc_t[4] = '{0, 1, 0, 0};
    logic [7:0] zero_t[9] = '{8'h00, 8'h71, 8'h72, 8'h73, 8'h74, 8'h78, 8'h4a, 8'h5b, 8'h6e};

    mlpwm_core u_dut (.clk(clk), .reset_n(reset_n), .shutdown_pin_n(shutdown_pin_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .serial_reset(serial_reset), .open_sense(open_sense), .short_sense(short_sense),
        .led_output(led_output), .channel_scale_value(channel_scale_value),
        .global_current_level(global_current_level), .analog_enable(analog_enable));
    mlpwm_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        u_host.read_reg(a, rd);
        check(32'(rd), 32'(exp));
    endtask : rd_check
    // on-cycles of channels 1..3 and cycles where ch1 and ch3 differ
    task automatic measure(input int cycles);
        c1 = 0;
        c2 = 0;
        c3 = 0;
        bad = 0;
        repeat (cycles) begin
            @(negedge clk);
            c1 += int'(led_output[0]);
            c2 += int'(led_output[1]);
            c3 += int'(led_output[2]);
            bad += int'(led_output[0] ^ led_output[2]);
        end
    endtask : measure
    // three status bytes against an 18-bit pattern
    task automatic fault_check(input logic [17:0] v);
        for (int i = 0; i < 3; i++) begin
            rd_check(8'(`MLPWM_ADDR_STATUS0 + i), 8'(v >> (8 * i)));
        end
    endtask : fault_check

    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // whole run is about 41k cycles; over twice that means a hang
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial begin
        reset_n = 1'b0;
        shutdown_pin_n = 1'b1;
        open_sense = 18'h2a5a5;
        short_sense = 18'h15a5a;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        foreach (zero_t[i]) rd_check(zero_t[i], 8'h00);
        u_host.write_reg(8'h30, 8'hff);
        rd_check(8'h30, 8'h00);
        u_host.write_reg(8'h4a, 8'h80);
        check(32'(channel_scale_value[7:0]), 32'h80);
        u_host.write_reg(8'h5b, 8'hff);
        rd_check(8'h5b, 8'hff);
        // ch1 = 0104, ch2 = 0000, ch3 = 0080
        u_host.write_reg(8'h01, 8'h04);
        u_host.write_reg(8'h02, 8'h01);
        u_host.write_reg(8'h03, 8'h00);
        u_host.write_reg(8'h04, 8'h00);
        u_host.write_reg(8'h05, 8'h80);
        u_host.write_reg(8'h06, 8'h00);
        u_host.write_reg(8'h00, 8'h01);
        measure(768);
        check(32'(c3), 32'h0);
        u_host.update_duty();
        measure(768);
        measure(768);
        check(32'(c1), 32'(4 * `MLPWM_TICK_CYCLES));
        u_host.write_reg(8'h00, 8'h00);
        measure(768);
        check(32'(c3), 32'h0);
        rd_check(8'h05, 8'h80);
        u_host.write_reg(8'h00, 8'h01);
        shutdown_pin_n = 1'b0;
        repeat (4) @(negedge clk);
        check(32'(analog_enable), 32'h0);
        measure(768);
        check(32'(c3), 32'h0);
        u_host.write_reg(8'h6e, 8'h5a);
        rd_check(8'h6e, 8'h5a);
        u_host.write_reg(8'h01, 8'h10);
        u_host.update_duty();
        shutdown_pin_n = 1'b1;
        n = 0;
        while (serial_reset !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 10), 32'h1);
        check(32'(analog_enable), 32'h1);
        check(32'({global_current_level, channel_scale_value[7:0]}), 32'h5a80);
        measure(768);
        measure(768);
        check(32'(c1), 32'(4 * `MLPWM_TICK_CYCLES));
        // ch1 is now 0110 once loaded
        for (int i = 0; i < 4; i++) begin
            t = `MLPWM_TICK_CYCLES << osc_t[i];
            d = 16'h0110 & ((256 << (2 * res_t[i])) - 1);
            per = (256 << (2 * res_t[i])) * t;
            u_host.write_reg(8'h00, 8'(1 | (res_t[i] << 1) | (osc_t[i] << 4)));
            u_host.update_duty();
            measure(per);
            measure(per);
            check(32'(c1), 32'(d * t));
            check(32'(c3), 32'(128 * t));
            check(32'(c2), 32'h0);
            check(32'(bad), 32'((d > 128 ? d - 128 : 128 - d) * t));
        end
        u_host.write_reg(8'h71, 8'h01);
        repeat (4) @(negedge clk);
        fault_check(18'h0);
        u_host.write_reg(8'h71, 8'h02);
        repeat (4) @(negedge clk);
        fault_check(18'h15a5a);
        u_host.write_reg(8'h71, 8'h03);
        repeat (4) @(negedge clk);
        fault_check(18'h2a5a5);
        u_host.write_reg(8'h71, 8'h00);
        open_sense = 18'h05a5a;
        short_sense = 18'h2a5a5;
        repeat (4) @(negedge clk);
        fault_check(18'h2a5a5);
        for (int r = 0; r < 4; r++) begin
            u_host.write_reg(8'h78, 8'(8'h10 | (r << 2)));
            rd_check(8'h78, 8'(8'h10 | (r << 2)));
        end
        complete_run();
    end
endmodule : test_multichannel_led_pwm_core
